// ===== logic/adcsc_control.v
// Converter sequencing, port pin set-up and register file
// Notes on behaviour
// - A port read returns zero for every pin set up as an analog channel.
// - Conversions run whatever the channel field and direction bits hold.
// - A selected pin driven as output converts its own driver level.
// - A selected pin used as a digital input is still converted.
// - Clearing the go flag during a conversion aborts it at once.
// - An aborted conversion leaves both result bytes untouched.
// - After an abort the next acquisition waits two bit periods.
// - After that wait acquisition restarts on the selected channel.
// - The first segment after go lasts one cycle up to one bit period.
// - Completion sets the done interrupt flag and clears the go flag.
// - Writing 0x01 to control register A turns on and picks channel 0.
// - Zero in config B means all analog, clock divided by 8, left justified.
`timescale 1ns/10ps
`default_nettype none
`include "adcsc_map.vh"

module adcsc_control #(
  parameter RC_DIV = 16,
  parameter PINS = 16
) (
  // Clock and reset
  input wire clk_in,
  input wire arst_n_in,
  // Register port
  input wire [3:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rdata_out,
  // Interrupt
  output reg irq_out,
  // Port pins
  input wire [PINS-1:0] pin_in,
  output reg [PINS-1:0] pin_out,
  output reg [PINS-1:0] pin_oe_n_out,
  // Analog front end
  input wire [9:0] sample_in,
  output reg [3:0] chan_sel_out,
  output reg acquire_out
);

  // ==========================================
  // Sequencer states
  localparam [4:0] ST_OFF = 5'b00001;
  localparam [4:0] ST_ACQ = 5'b00010;
  localparam [4:0] ST_SYNC = 5'b00100;
  localparam [4:0] ST_CONV = 5'b01000;
  localparam [4:0] ST_HOLD = 5'b10000;
  localparam [7:0] CTRL_A_RST = `ADCSC_RST_CTRL_A;

  // ==========================================
  // Declarations
  reg [4:0] state;
  reg [4:0] next_state;
  reg conv_on;
  reg [3:0] chan;
  reg [7:0] cfg_b;
  reg [7:0] res_hi;
  reg [7:0] res_lo;
  reg done_flag;
  reg done_en;
  reg [PINS-1:0] dir;
  reg [PINS-1:0] latch;
  reg [3:0] tad_cnt;
  reg [3:0] next_tad_cnt;
  reg [9:0] held;
  reg [7:0] next_rdata;
  reg done_evt;
  reg abort_evt;
  reg start_evt;
  wire tad_tick;
  wire wr_ctrl;
  wire go_wr;
  wire busy;
  wire [PINS-1:0] analog;
  wire [PINS-1:0] port_view;
  wire [9:0] conv_in;

  // ==========================================
  // Helpers

  // Pin index analog when below the count left by the config field
  function [PINS-1:0] analog_map;
    input [3:0] pcfg;
    integer i;
    begin
      analog_map = {PINS{1'b0}};
      for (i = 0; i < PINS; i = i + 1) begin
        if (i < (PINS - pcfg)) begin
          analog_map[i] = 1'b1;
        end
      end
    end
  endfunction

  // High byte of a justified result
  function [7:0] just_hi;
    input [9:0] r;
    input rj;
    begin
      if (rj) begin
        just_hi = {6'h00, r[9:8]};
      end else begin
        just_hi = r[9:2];
      end
    end
  endfunction

  // Low byte of a justified result
  function [7:0] just_lo;
    input [9:0] r;
    input rj;
    begin
      if (rj) begin
        just_lo = r[7:0];
      end else begin
        just_lo = {r[1:0], 6'h00};
      end
    end
  endfunction

  // ==========================================
  // Conversion-bit period divider
  adcsc_tick_gen #(
    .RC_DIV(RC_DIV)
  ) u_tick (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .run_in(conv_on),
    .clk_sel_in(cfg_b[`ADCSC_CFG_CLK_MSB:`ADCSC_CFG_CLK_LSB]),
    .tick_out(tad_tick)
  );

  // ==========================================
  // Decode and derived terms
  assign wr_ctrl = wr_in && (addr_in == `ADCSC_OFF_CTRL_A);
  assign go_wr = wdata_in[`ADCSC_CTRL_GO];
  assign busy = (state == ST_SYNC) || (state == ST_CONV);
  assign analog = analog_map(
    cfg_b[`ADCSC_CFG_PCFG_MSB:`ADCSC_CFG_PCFG_LSB]);
  assign port_view = pin_in & ~analog;

  // Output pin converts its driver level, else the pad level
  assign conv_in = dir[chan] ? sample_in :
    {10{latch[chan]}};

  // ==========================================
  // Sequencer next state; channel and direction never gate it
  always @* begin
    next_state = state;
    next_tad_cnt = tad_cnt;
    start_evt = 1'b0;
    abort_evt = 1'b0;
    done_evt = 1'b0;
    case (state)
      ST_OFF: begin
        if (conv_on) begin
          next_state = ST_ACQ;
        end
      end
      ST_ACQ: begin
        // Go set while on starts a conversion
        if (wr_ctrl && go_wr && wdata_in[`ADCSC_CTRL_ON]) begin
          next_state = ST_SYNC;
          start_evt = 1'b1;
        end
      end
      ST_SYNC: begin
        // Wait for the bit clock edge: one cycle to one period
        if (wr_ctrl && !go_wr) begin
          next_state = ST_HOLD;
          next_tad_cnt = 4'h0;
          abort_evt = 1'b1;
        end else if (tad_tick) begin
          next_state = ST_CONV;
          next_tad_cnt = 4'h0;
        end
      end
      ST_CONV: begin
        if (wr_ctrl && !go_wr) begin
          next_state = ST_HOLD;
          next_tad_cnt = 4'h0;
          abort_evt = 1'b1;
        end else if (tad_tick) begin
          if (tad_cnt == `ADCSC_CONV_TADS - 4'h1) begin
            next_state = ST_ACQ;
            done_evt = 1'b1;
          end else begin
            next_tad_cnt = tad_cnt + 4'h1;
          end
        end
      end
      ST_HOLD: begin
        // Two bit periods before acquisition resumes
        if (tad_tick) begin
          if (tad_cnt == `ADCSC_ABORT_TADS - 4'h1) begin
            next_state = ST_ACQ;
          end else begin
            next_tad_cnt = tad_cnt + 4'h1;
          end
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
    // Switching off ends any activity
    if (!conv_on || (wr_ctrl && !wdata_in[`ADCSC_CTRL_ON])) begin
      next_state = ST_OFF;
      done_evt = 1'b0;
    end
  end

  // ==========================================
  // Sequencer state, counters and held sample
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= ST_OFF;
      tad_cnt <= 4'h0;
      held <= 10'h000;
    end else begin
      state <= next_state;
      tad_cnt <= next_tad_cnt;
      if (start_evt) begin
        held <= conv_in;
      end
    end
  end

  // ==========================================
  // Control register A and config register B
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      conv_on <= CTRL_A_RST[`ADCSC_CTRL_ON];
      chan <= CTRL_A_RST[`ADCSC_CTRL_CH_MSB:`ADCSC_CTRL_CH_LSB];
      cfg_b <= `ADCSC_RST_CFG_B;
    end else begin
      if (wr_ctrl) begin
        conv_on <= wdata_in[`ADCSC_CTRL_ON];
        chan <= wdata_in[`ADCSC_CTRL_CH_MSB:`ADCSC_CTRL_CH_LSB];
      end
      if (wr_in && (addr_in == `ADCSC_OFF_CFG_B)) begin
        cfg_b <= wdata_in;
      end
    end
  end

  // ==========================================
  // Result pair: written by software or by a completed conversion
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      res_hi <= `ADCSC_RST_RES;
      res_lo <= `ADCSC_RST_RES;
    end else if (done_evt) begin
      res_hi <= just_hi(held, cfg_b[`ADCSC_CFG_RJUST]);
      res_lo <= just_lo(held, cfg_b[`ADCSC_CFG_RJUST]);
    end else begin
      // Abort path never reaches here with new data
      if (wr_in && (addr_in == `ADCSC_OFF_RES_HI)) begin
        res_hi <= wdata_in;
      end
      if (wr_in && (addr_in == `ADCSC_OFF_RES_LO)) begin
        res_lo <= wdata_in;
      end
    end
  end

  // ==========================================
  // Done flag: set wins over a write-one clear
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      done_flag <= 1'b0;
      done_en <= 1'b0;
    end else begin
      if (done_evt) begin
        done_flag <= 1'b1;
      end else if (wr_in && (addr_in == `ADCSC_OFF_IRQ_FLAG)
                   && wdata_in[0]) begin
        done_flag <= 1'b0;
      end
      if (wr_in && (addr_in == `ADCSC_OFF_IRQ_EN)) begin
        done_en <= wdata_in[0];
      end
    end
  end

  // ==========================================
  // Port direction and output latches
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dir <= `ADCSC_RST_DIR;
      latch <= {PINS{1'b0}};
    end else if (wr_in) begin
      case (addr_in)
        `ADCSC_OFF_DIR_LO: dir[7:0] <= wdata_in;
        `ADCSC_OFF_DIR_HI: dir[PINS-1:8] <= wdata_in[PINS-9:0];
        `ADCSC_OFF_LAT_LO: latch[7:0] <= wdata_in;
        `ADCSC_OFF_LAT_HI: latch[PINS-1:8] <= wdata_in[PINS-9:0];
        default: begin
          dir <= dir;
        end
      endcase
    end
  end

  // ==========================================
  // Read data mux
  always @* begin
    case (addr_in)
      `ADCSC_OFF_CTRL_A: begin
        next_rdata = {chan, 1'b0, busy, 1'b0, conv_on};
      end
      `ADCSC_OFF_CFG_B: next_rdata = cfg_b;
      `ADCSC_OFF_RES_HI: next_rdata = res_hi;
      `ADCSC_OFF_RES_LO: next_rdata = res_lo;
      `ADCSC_OFF_IRQ_FLAG: next_rdata = {7'h00, done_flag};
      `ADCSC_OFF_IRQ_EN: next_rdata = {7'h00, done_en};
      `ADCSC_OFF_PORT_LO: next_rdata = port_view[7:0];
      `ADCSC_OFF_PORT_HI: next_rdata = port_view[PINS-1:8];
      `ADCSC_OFF_DIR_LO: next_rdata = dir[7:0];
      `ADCSC_OFF_DIR_HI: next_rdata = dir[PINS-1:8];
      `ADCSC_OFF_LAT_LO: next_rdata = latch[7:0];
      `ADCSC_OFF_LAT_HI: next_rdata = latch[PINS-1:8];
      default: next_rdata = 8'h00;
    endcase
  end

  // ==========================================
  // Registered outputs
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_out <= 8'h00;
      irq_out <= 1'b0;
      pin_out <= {PINS{1'b0}};
      pin_oe_n_out <= {PINS{1'b1}};
      chan_sel_out <= 4'h0;
      acquire_out <= 1'b0;
    end else begin
      // Read data stands only in the cycle after the strobe
      rdata_out <= rd_in ? next_rdata : 8'h00;
      irq_out <= (done_flag && done_en) || (done_evt && done_en);
      pin_out <= latch;
      pin_oe_n_out <= dir; // Low while driving
      chan_sel_out <= chan;
      // Sampling switch closed while waiting for go
      acquire_out <= (next_state == ST_ACQ);
    end
  end

endmodule // adcsc_control

`default_nettype wire

// ===== logic/adcsc_map.vh
// Register offsets, field positions, reset values and timing counts
`ifndef ADCSC_MAP_VH
`define ADCSC_MAP_VH

// =============================================
// Register offsets
`define ADCSC_OFF_CTRL_A 4'h0
`define ADCSC_OFF_CFG_B 4'h1
`define ADCSC_OFF_RES_HI 4'h2
`define ADCSC_OFF_RES_LO 4'h3
`define ADCSC_OFF_IRQ_FLAG 4'h4
`define ADCSC_OFF_IRQ_EN 4'h5
`define ADCSC_OFF_PORT_LO 4'h6
`define ADCSC_OFF_PORT_HI 4'h7
`define ADCSC_OFF_DIR_LO 4'h8
`define ADCSC_OFF_DIR_HI 4'h9
`define ADCSC_OFF_LAT_LO 4'hA
`define ADCSC_OFF_LAT_HI 4'hB

// =============================================
// Field positions of converter_control_a
`define ADCSC_CTRL_ON 0
`define ADCSC_CTRL_GO 2
`define ADCSC_CTRL_CH_LSB 4
`define ADCSC_CTRL_CH_MSB 7

// =============================================
// Field positions of converter_config_b
`define ADCSC_CFG_CLK_LSB 0
`define ADCSC_CFG_CLK_MSB 1
`define ADCSC_CFG_RJUST 2
`define ADCSC_CFG_PCFG_LSB 4
`define ADCSC_CFG_PCFG_MSB 7

// =============================================
// Conversion clock selections
`define ADCSC_CLK_DIV8 2'h0
`define ADCSC_CLK_DIV32 2'h1
`define ADCSC_CLK_DIV64 2'h2
`define ADCSC_CLK_RC 2'h3

// =============================================
// Reset values
`define ADCSC_RST_CTRL_A 8'h00
`define ADCSC_RST_CFG_B 8'h00
`define ADCSC_RST_RES 8'h00
`define ADCSC_RST_DIR 16'hFFFF

// =============================================
// Timing counts, in conversion-bit periods
`define ADCSC_CONV_TADS 4'hC
`define ADCSC_ABORT_TADS 4'h2

`endif

// ===== logic/adcsc_tick_gen.v
// Conversion-bit period divider producing a one-cycle enable pulse
`timescale 1ns/10ps
`default_nettype none
`include "adcsc_map.vh"

module adcsc_tick_gen #(
  parameter RC_DIV = 16
) (
  // Clock and reset
  input wire clk_in,
  input wire arst_n_in,
  // Control
  input wire run_in,
  input wire [1:0] clk_sel_in,
  // Enable pulse
  output reg tick_out
);

  reg [7:0] count;
  reg [7:0] last;

  // Terminal count from the clock selection
  always @* begin
    case (clk_sel_in)
      `ADCSC_CLK_DIV8: last = 8'h07;
      `ADCSC_CLK_DIV32: last = 8'h1F;
      `ADCSC_CLK_DIV64: last = 8'h3F;
      default: last = RC_DIV[7:0] - 8'h01;
    endcase
  end

  // Free count while running, pulse at wrap
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count <= 8'h00;
      tick_out <= 1'b0;
    end else if (!run_in) begin
      count <= 8'h00;
      tick_out <= 1'b0;
    end else if (count >= last) begin
      count <= 8'h00;
      tick_out <= 1'b1;
    end else begin
      count <= count + 8'h01;
      tick_out <= 1'b0;
    end
  end

endmodule // adcsc_tick_gen

`default_nettype wire

// ===== test/adcsc_control_assertions.sv
// Port checks on the converter control block
`timescale 1ns/10ps
`default_nettype none

module adcsc_checker (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Register port
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  // Status outputs
  input wire logic irq_out,
  input wire logic [3:0] chan_sel_out,
  input wire logic acquire_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);
  // ==========================================
  // Shadow state
  logic on_q, en_q, busy_q, ab_q;
  logic [7:0] cfg_q, low_cnt;
  wire wr_a = wr_in && addr_in == 4'h0;
  wire abort = wr_a && wdata_in[0] && !wdata_in[2] && busy_q;

  // Mirrors written bits, busy span and low time
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      on_q <= 1'b0;
      en_q <= 1'b0;
      busy_q <= 1'b0;
      ab_q <= 1'b0;
      cfg_q <= 8'h00;
      low_cnt <= 8'h00;
    end else begin
      if (wr_a) on_q <= wdata_in[0];
      if (wr_in && addr_in == 4'h1) cfg_q <= wdata_in;
      if (wr_in && addr_in == 4'h5) en_q <= wdata_in[0];
      if (acquire_out) busy_q <= 1'b0;
      else if ($fell(acquire_out) && on_q) busy_q <= 1'b1;
      if (acquire_out) ab_q <= 1'b0;
      else if (abort) ab_q <= 1'b1;
      low_cnt <= acquire_out ? 8'h00 : low_cnt + {7'h00, low_cnt != 8'hff};
    end
  end

  // ==========================================
  // Properties
  property p_rd_idle;
    !rd_in |=> rdata_out == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  property p_port_analog;
    rd_in && addr_in[3:1] == 3'h3 && cfg_q[7:4] == 4'h0 |=> rdata_out == 8'h00;
  endproperty
  a_port_analog: assert property (p_port_analog) else $error("analog pin read");
  property p_irq_en;
    irq_out |-> $past(en_q);
  endproperty
  a_irq_en: assert property (p_irq_en) else $error("masked irq high");
  property p_irq_done;
    $rose(irq_out) |-> acquire_out;
  endproperty
  a_irq_done: assert property (p_irq_done) else $error("irq while busy");
  property p_turn_on;
    wr_a && wdata_in == 8'h01 && !on_q |->
      ##[1:3] (acquire_out && chan_sel_out == 4'h0);
  endproperty
  a_turn_on: assert property (p_turn_on) else $error("no acquire");
  property p_off;
    wr_a && !wdata_in[0] |-> ##2 !acquire_out;
  endproperty
  a_off: assert property (p_off) else $error("still acquiring");
  property p_abort;
    abort |=> (!acquire_out)[*8] ##[1:24] acquire_out;
  endproperty
  a_abort: assert property (p_abort) else $error("abort wait wrong");
  property p_conv_len;
    $rose(acquire_out) && busy_q && !ab_q && cfg_q[1:0] == 2'h0 |->
      low_cnt >= 8'h5e && low_cnt <= 8'h6a;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("bad length");
  c_abort: cover property (abort);
  c_done: cover property ($rose(irq_out));
  c_conv: cover property ($rose(acquire_out) && busy_q && !ab_q);
endmodule // adcsc_checker

bind adcsc_control adcsc_checker adcsc_checker_inst (.clk_in, .arst_n_in,
  .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .irq_out,
  .chan_sel_out, .acquire_out);
`default_nettype wire

// ===== test/adcsc_pads.sv
// Pad and analog front end model for the converter inputs
`timescale 1ns/10ps
`default_nettype none

module adcsc_pads (
  // Pin drive from the device
  input wire logic [15:0] drv_in,
  input wire logic [15:0] oe_n_in,
  // Outside world
  input wire logic [15:0] ext_in,
  input wire logic [9:0] base_in,
  input wire logic [3:0] chan_sel_in,
  // To the device
  output logic [15:0] pad_out,
  output logic [9:0] sample_out
);
  // Pad level, own driver wins where enabled
  assign pad_out = (drv_in & ~oe_n_in) | (ext_in & oe_n_in);
  // Each channel carries a distinct level
  assign sample_out = base_in ^ {6'h00, chan_sel_in};
endmodule // adcsc_pads
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic rd_d = 1'b0;
  logic [15:0] ext = 16'hffff;
  logic [9:0] base = 10'h000;
  logic [7:0] exp_q[$];
  int fail_count = 0;
  int n_compared = 0;
  wire [7:0] rdata_out;
  wire irq_out, acquire_out;
  wire [15:0] pin_in, pin_out, pin_oe_n_out;
  wire [9:0] sample_in;
  wire [3:0] chan_sel_out;

  // 100 MHz clock
  always #5 clk_in = ~clk_in;

  adcsc_control #(.RC_DIV(2), .PINS(16)) adcsc_control_inst (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .irq_out(irq_out), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n_out(pin_oe_n_out),
    .sample_in(sample_in), .chan_sel_out(chan_sel_out),
    .acquire_out(acquire_out));

  adcsc_pads adcsc_pads_inst (.drv_in(pin_out), .oe_n_in(pin_oe_n_out),
    .ext_in(ext), .base_in(base), .chan_sel_in(chan_sel_out),
    .pad_out(pin_in), .sample_out(sample_in));

  task automatic complete_run();
    if (fail_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle strobes, then a quiet cycle
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    if (w) wr_in <= 1'b1;
    else rd_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask

  task automatic wait_acq();
    int i = 0;
    while (acquire_out !== 1'b1 && i < 300) begin
      @(posedge clk_in);
      i++;
    end
    if (acquire_out !== 1'b1) begin
      fail_count++;
      complete_run();
    end
  endtask

  // One full conversion and its readback
  task automatic conv(input logic [3:0] ch, input logic [9:0] r,
                      input logic rj, input logic en);
    wr(4'h0, {ch, 4'h1});
    repeat (4) @(posedge clk_in);
    wr(4'h0, {ch, 4'h5});
    rd(4'h0, {ch, 4'h5});
    wait_acq();
    rd(4'h4, 8'h01);
    rd(4'h0, {ch, 4'h1});
    rd(4'h2, rj ? {6'h00, r[9:8]} : r[9:2]);
    rd(4'h3, rj ? r[7:0] : {r[1:0], 6'h00});
    chk(16'(irq_out), 16'(en));
    wr(4'h4, 8'h01);
  endtask

  // Compares each read answer with the oldest note
  always @(posedge clk_in) begin
    rd_d <= rd_in;
    if (rd_d)
      chk(16'(rdata_out), 16'(exp_q.pop_front()));
  end

  // Main sequence
  initial begin
    void'($urandom(32'he430));
    ext = 16'($urandom);
    base = 10'($urandom);
    repeat (4) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
    chk(pin_oe_n_out, 16'hffff);
    rd(4'h1, 8'h00);
    rd(4'h8, 8'hff);
    wr(4'hc, 8'h5a);
    rd(4'hc, 8'h00);
    rd(4'h6, 8'h00);
    rd(4'h7, 8'h00);
    wr(4'h1, 8'h80);
    rd(4'h6, 8'h00);
    rd(4'h7, ext[15:8]);
    wr(4'h1, 8'h00);
    wr(4'h5, 8'h01);
    conv(4'h0, base, 1'b0, 1'b1);
    wr(4'h1, 8'h04);
    wr(4'h5, 8'h00);
    conv(4'h9, base ^ 10'h009, 1'b1, 1'b0);
    wr(4'hb, 8'h80);
    wr(4'h9, 8'h7f);
    conv(4'hf, 10'h3ff, 1'b1, 1'b0);
    chk(pin_out, 16'h8000);
    chk(pin_oe_n_out, 16'h7fff);
    wr(4'h9, 8'hff);
    wr(4'h1, 8'he4);
    rd(4'h6, {ext[7:2], 2'b00});
    conv(4'h3, base ^ 10'h003, 1'b1, 1'b0);
    wr(4'h2, 8'ha5);
    wr(4'h3, 8'h3c);
    repeat (4) @(posedge clk_in);
    wr(4'h0, 8'h35);
    repeat (20) @(posedge clk_in);
    wr(4'h0, 8'h31);
    rd(4'h0, 8'h31);
    rd(4'h2, 8'ha5);
    rd(4'h3, 8'h3c);
    wait_acq();
    rd(4'h4, 8'h00);
    chk(16'(chan_sel_out), 16'h0003);
    wr(4'h1, 8'h03);
    conv(4'h5, base ^ 10'h005, 1'b0, 1'b0);
    wr(4'h0, 8'h00);
    repeat (3) @(posedge clk_in);
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
